// ### hw/rci_pkg.sv
// Purpose: shared constants of the remote command interpreter
// Assumes: 20 MHz core clock
// Notes:   fault index 0..10 maps to codes 67..77 and messages E3..E13
package rci_pkg;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          BAUD_A      = 1200;
  localparam int          BAUD_B      = 2400;
  localparam int          BAUD_C      = 9600;
  localparam int          BAUD_D      = 19600;
  localparam int          BAUD_E      = 76800;
  localparam logic [14:0] DIV_A       = 15'(CLK_HZ / BAUD_A);
  localparam logic [14:0] DIV_B       = 15'(CLK_HZ / BAUD_B);
  localparam logic [14:0] DIV_C       = 15'(CLK_HZ / BAUD_C);
  localparam logic [14:0] DIV_D       = 15'(CLK_HZ / BAUD_D);
  localparam logic [14:0] DIV_E       = 15'(CLK_HZ / BAUD_E);
  localparam int          SEL_STRAP   = 5;
  localparam logic [4:0]  ADDR_MIN    = 5'h01;
  localparam logic [4:0]  ADDR_MAX    = 5'h1E;
  localparam logic [7:0]  CH_LF       = 8'h0A;
  localparam logic [7:0]  CH_E        = 8'h45;
  localparam logic [7:0]  CH_P        = 8'h50;
  localparam logic [7:0]  CH_G        = 8'h47;
  localparam logic [7:0]  CH_R        = 8'h52;
  localparam logic [7:0]  CH_0        = 8'h30;
  localparam logic [7:0]  CH_9        = 8'h39;
  localparam logic [2:0]  MAX_DIGITS  = 3'h4;
  localparam logic [2:0]  GAIN_DIGITS = 3'h4;
  localparam logic [13:0] GAIN_TOP    = 14'h0FFF;
  localparam logic [11:0] GAIN_MIN    = 12'hFFF;
  localparam int          NFAULT      = 11;
  localparam logic [7:0]  STB_BASE    = 8'h43;
  localparam logic [3:0]  MSG_BASE    = 4'h3;
  localparam logic [3:0]  MSG_TEN     = 4'hA;
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_DEPTH  = 8;
endpackage

// ### hw/rci_fifo_if.sv
// Purpose: valid/ready carrier around the transmit FIFO
// Assumes: one clock domain
// Notes:   src fills, snk drains
interface rci_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport src  (output wr_valid, wr_data, input wr_ready);
  modport snk  (input rd_valid, rd_data, output rd_ready);
endinterface

// ### hw/rci_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   rd_data is the registered head entry
module rci_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  rci_fifo_if.fifo  port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } rci_fifo_s;
  rci_fifo_s q_reg;
  rci_fifo_s q_next;
  logic      push;
  logic      pop;

  // Honest flags from the occupancy count
  assign port.wr_ready = (q_reg.cnt != (AW+1)'(DEPTH));
  assign port.rd_valid = (q_reg.cnt != '0);
  assign port.rd_data  = q_reg.mem[q_reg.rp];
  assign push          = port.wr_valid & port.wr_ready;
  assign pop           = port.rd_valid & port.rd_ready;

  // Pointer and count update
  always_comb
  begin
    q_next = q_reg;
    if (push)
    begin
      q_next.mem[q_reg.wp] = port.wr_data;
      q_next.wp            = q_reg.wp + 1'b1;
    end
    if (pop)
      q_next.rp = q_reg.rp + 1'b1;
    q_next.cnt = q_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      q_reg <= '0;
    else if (clk_en_i)
      q_reg <= q_next;
  end
endmodule

// ### hw/rci_top.sv
// Purpose: remote command interpreter, parallel bus or serial line
// Assumes: inputs synchronous to core_clk_i; bus handshake done outside
// Notes:   bad command/parameter and transmission errors not reported
// Operation
// - Bus address valid only one to thirty
// - Address straps binary, switch one is LSB
// - Frame: letter, up to four digits, LF
// - Upper-case letters only match commands
// - Bus ends command on LF or EOI
// - Character after terminator starts new command
// - Service request while any error pending, parallel mode only
// - Status byte holds binary error code
// - Bad command/parameter/transmission errors not reported
// - Serial link valid only with carrier detect
// - Transmit only while clear-to-send asserted
// - Finish current character when clear-to-send drops
// - Terminal ready held asserted in serial mode
// - Request-to-send gates incoming serial data
// - Serial terminator is line feed only
// - Serial error message sent immediately; code queues it only in remote mode
// - Serial frame eight data, no parity, one stop
// - Power command: zero off, one on
// - Gain command loads four-digit value
// - Reset clears faults whose cause is gone
// - Strap six selects serial, else parallel
// - Straps read only once after power-up
// - One-hot straps pick baud, else 1200
module rci_top
  import rci_pkg::*;
#(
  parameter logic [14:0] BAUD_DIV_A = DIV_A,
  parameter logic [14:0] BAUD_DIV_B = DIV_B
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  input  wire logic [5:0]        straps_i,
  input  wire logic              remote_i,
  input  wire logic              local_power_btn_i,
  input  wire logic [11:0]       local_gain_i,
  input  wire logic              local_fault_reset_i,
  input  wire logic [NFAULT-1:0] fault_i,
  input  wire logic [7:0]        bus_data_i,
  input  wire logic              bus_valid_i,
  input  wire logic              bus_eoi_i,
  output logic                   bus_ready_o,
  output logic [4:0]             bus_addr_o,
  output logic                   bus_addr_ok_o,
  output logic                   srq_o,
  output logic [7:0]             stb_o,
  input  wire logic              rxd_i,
  input  wire logic              dcd_i,
  input  wire logic              cts_i,
  output logic                   txd_o,
  output logic                   rts_o,
  output logic                   dtr_o,
  output logic                   link_ok_o,
  output logic                   serial_mode_o,
  output logic                   power_on_o,
  output logic [11:0]            gain_o,
  output logic [NFAULT-1:0]      fault_latched_o
);
  typedef enum logic [1:0] {
    PS_LETTER = 2'b00,
    PS_PARAM  = 2'b01,
    PS_BAD    = 2'b10
  } rci_pst_e;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_E    = 3'b001,
    MS_TENS = 3'b010,
    MS_ONES = 3'b011,
    MS_LF   = 3'b100
  } rci_mst_e;
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_START = 2'b01,
    RS_DATA  = 2'b10,
    RS_STOP  = 2'b11
  } rci_rst_e;
  typedef struct packed {
    logic              strap_done;
    logic              serial;
    logic [4:0]        addr;
    logic [14:0]       div;
    logic              remote_q;
    logic              btn_q;
    logic              power;
    logic [11:0]       gain;
    logic [NFAULT-1:0] latched;
    logic [NFAULT-1:0] to_send;
    rci_pst_e          pst;
    logic [7:0]        cmd;
    logic [2:0]        ndig;
    logic [13:0]       val;
    rci_mst_e          mst;
    logic [3:0]        mnum;
    rci_rst_e          rst;
    logic [14:0]       rcnt;
    logic [2:0]        rbit;
    logic [7:0]        rsh;
    logic              txbusy;
    logic [14:0]       tcnt;
    logic [3:0]        tbit;
    logic [9:0]        tsh;
    logic [7:0]        stb;
    logic              srq;
  } rci_state_s;
  rci_state_s q_reg, q_next;
  rci_fifo_if #(.W(FIFO_W)) txq ();
  // Lowest set bit: {found, index}
  function automatic logic [4:0] low_idx(input logic [NFAULT-1:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NFAULT - 1; i >= 0; i--)
      if (v[i])
        r = {1'b1, 4'(i)};
    return r;
  endfunction
  // Transmit queue between message builder and serial sender
  rci_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .port       (txq)
  );
  // Handshake terms
  assign rts_o       = q_reg.strap_done & q_reg.serial
                     & q_reg.remote_q;
  assign bus_ready_o = q_reg.strap_done & ~q_reg.serial & q_reg.remote_q;
  assign txq.rd_ready = ~q_reg.txbusy & cts_i & q_reg.serial;
  assign txq.wr_valid = (q_reg.mst != MS_IDLE);
  // Message character for the current builder state
  always_comb
  begin
    case (q_reg.mst)
      MS_E:    txq.wr_data = CH_E;
      MS_TENS: txq.wr_data = CH_0 + 8'h01;
      MS_ONES: txq.wr_data = CH_0 + {4'h0, (q_reg.mnum >= MSG_TEN)
                             ? q_reg.mnum - MSG_TEN : q_reg.mnum};
      default: txq.wr_data = CH_LF;
    endcase
  end
  // Outputs from registered state; link_ok_o also follows dcd_i directly
  assign bus_addr_o      = q_reg.addr;
  assign bus_addr_ok_o   = q_reg.strap_done & ~q_reg.serial
                         & (q_reg.addr >= ADDR_MIN)
                         & (q_reg.addr <= ADDR_MAX);
  assign srq_o           = q_reg.srq;
  assign stb_o           = q_reg.stb;
  assign txd_o           = q_reg.tsh[0];
  assign dtr_o           = q_reg.strap_done & q_reg.serial;
  assign link_ok_o       = rts_o & dcd_i;
  assign serial_mode_o   = q_reg.serial;
  assign power_on_o      = q_reg.power;
  assign gain_o          = q_reg.gain;
  assign fault_latched_o = q_reg.latched;
  // Next-state logic of the whole block
  always_comb
  begin
    logic              rx_stb, in_v, is_lf, term, is_dig, clr;
    logic [7:0]        in_c;
    logic [4:0]        li;
    logic [NFAULT-1:0] newf;
    rx_stb = 1'b0;
    in_v   = 1'b0;
    in_c   = '0;
    is_lf  = 1'b0;
    term   = 1'b0;
    is_dig = 1'b0;
    clr    = 1'b0;
    li     = '0;
    newf   = '0;
    q_next = q_reg;
    // Strap capture on the first enabled cycle after reset
    if (!q_reg.strap_done)
    begin
      q_next.strap_done = 1'b1;
      q_next.serial     = straps_i[SEL_STRAP];
      q_next.addr       = straps_i[4:0];
      case (straps_i[4:0])
        5'h02:   q_next.div = BAUD_DIV_B;
        5'h04:   q_next.div = DIV_C;
        5'h08:   q_next.div = DIV_D;
        5'h10:   q_next.div = DIV_E;
        default: q_next.div = BAUD_DIV_A;
      endcase
    end
    // Serial receiver, 8 data bits, 1 stop, no parity
    q_next.rcnt = q_reg.rcnt + 15'h0001;
    case (q_reg.rst)
      RS_IDLE:
      begin
        q_next.rcnt = '0;
        if (rts_o && !rxd_i)
          q_next.rst = RS_START;
      end
      RS_START:
        if (q_reg.rcnt == {1'b0, q_reg.div[14:1]})
        begin
          q_next.rcnt = '0;
          q_next.rbit = '0;
          q_next.rst  = rxd_i ? RS_IDLE : RS_DATA;
        end
      RS_DATA:
        if (q_reg.rcnt == q_reg.div - 15'h0001)
        begin
          q_next.rcnt = '0;
          q_next.rsh  = {rxd_i, q_reg.rsh[7:1]};
          q_next.rbit = q_reg.rbit + 3'h1;
          if (q_reg.rbit == 3'h7)
            q_next.rst = RS_STOP;
        end
      RS_STOP:
        if (q_reg.rcnt == q_reg.div - 15'h0001)
        begin
          rx_stb     = rxd_i;                          // Framing check
          q_next.rst = RS_IDLE;
        end
      default: q_next.rst = RS_IDLE;
    endcase
    // Character source: serial needs carrier, bus may flag end
    if (q_reg.serial)
    begin
      in_v = rx_stb & dcd_i;
      in_c = q_reg.rsh;
    end
    else
    begin
      in_v = bus_valid_i & bus_ready_o & bus_addr_ok_o;
      in_c = bus_data_i;
    end
    is_lf  = (in_c == CH_LF);
    term   = is_lf | (~q_reg.serial & bus_eoi_i);
    is_dig = (in_c >= CH_0) && (in_c <= CH_9);
    // Command parser
    if (in_v)
    begin
      case (q_reg.pst)
        PS_LETTER:
          if (!is_lf)
          begin
            q_next.cmd  = in_c;
            q_next.ndig = '0;
            q_next.val  = '0;
            q_next.pst  = PS_PARAM;
          end
        PS_PARAM:
          if (!is_lf)
          begin
            if (is_dig && q_reg.ndig < MAX_DIGITS)
            begin
              q_next.val  = 14'(q_reg.val * 14'h000A)
                          + {10'h000, 4'(in_c - CH_0)};
              q_next.ndig = q_reg.ndig + 3'h1;
            end
            else
              q_next.pst = PS_BAD;                     // Silently dropped
          end
        default: ;
      endcase
      // Terminator executes a clean frame and rearms for a letter
      if (term)
      begin
        if (q_next.pst == PS_PARAM)
        begin
          case (q_next.cmd)
            CH_P:
              if (q_next.ndig == 3'h1 && q_next.val <= 14'h0001)
                q_next.power = q_next.val[0];
            CH_G:
              if (q_next.ndig == GAIN_DIGITS
                  && q_next.val <= GAIN_TOP)
                q_next.gain = q_next.val[11:0];
            CH_R:
              if (q_next.ndig == 3'h0)
                clr = 1'b1;
            default: ;
          endcase
        end
        q_next.pst = PS_LETTER;
      end
    end
    // Local controls act only outside remote mode
    q_next.remote_q = remote_i;
    q_next.btn_q    = local_power_btn_i;
    if (!remote_i)
    begin
      q_next.gain = local_gain_i;
      if (local_power_btn_i && !q_reg.btn_q)
        q_next.power = ~q_reg.power;
      clr = local_fault_reset_i;
    end
    else if (!q_reg.remote_q)
    begin
      q_next.power = 1'b0;
      q_next.gain  = GAIN_MIN;
      q_next.pst   = PS_LETTER;
    end
    // Fault latches: a present cause always wins over a clear
    newf = fault_i & ~q_reg.latched;
    q_next.latched = clr ? fault_i
                   : (q_reg.latched | fault_i);
    // Status byte and service request from the lowest pending fault
    li = low_idx(q_next.latched);
    q_next.stb = li[4] ? STB_BASE + {4'h0, li[3:0]} : 8'h00;
    q_next.srq = li[4] & ~q_next.serial;
    // Message builder: pick a new fault and queue its text
    li = low_idx(q_reg.to_send);
    case (q_reg.mst)
      MS_IDLE:
        if (li[4])
        begin
          q_next.mnum = MSG_BASE + li[3:0];
          q_next.to_send[li[3:0]] = 1'b0;
          q_next.mst = MS_E;
        end
      MS_E:
        if (txq.wr_ready)
          q_next.mst = (q_reg.mnum >= MSG_TEN) ? MS_TENS : MS_ONES;
      MS_TENS:
        if (txq.wr_ready)
          q_next.mst = MS_ONES;
      MS_ONES:
        if (txq.wr_ready)
          q_next.mst = MS_LF;
      MS_LF:
        if (txq.wr_ready)
          q_next.mst = MS_IDLE;
      default: q_next.mst = MS_IDLE;
    endcase
    if (q_reg.serial && q_reg.remote_q)
      q_next.to_send = q_next.to_send | newf;
    // Serial sender; a started character always completes
    if (txq.rd_valid && txq.rd_ready)
    begin
      q_next.tsh    = {1'b1, txq.rd_data, 1'b0};
      q_next.tbit   = '0;
      q_next.tcnt   = '0;
      q_next.txbusy = 1'b1;
    end
    else if (q_reg.txbusy)
    begin
      q_next.tcnt = q_reg.tcnt + 15'h0001;
      if (q_reg.tcnt == q_reg.div - 15'h0001)
      begin
        q_next.tcnt = '0;
        q_next.tsh  = {1'b1, q_reg.tsh[9:1]};
        q_next.tbit = q_reg.tbit + 4'h1;
        if (q_reg.tbit == 4'h9)
          q_next.txbusy = 1'b0;
      end
    end
  end
  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      q_reg     <= '0;
      q_reg.tsh <= 10'h3FF;                            // Line idles high
    end
    else if (clk_en_i)
      q_reg <= q_next;
  end
endmodule

// ### test/rci_assertions.sv
// Purpose: port checks of the command interpreter
// Assumes: bound to rci_top, one clock
// Notes:   serial bit timing is judged by the bench
module rci_assertions
  import rci_pkg::*;
#(
  parameter logic [14:0] BAUD_DIV_A = DIV_A,
  parameter logic [14:0] BAUD_DIV_B = DIV_B
) (
  input wire logic              core_clk_i,
  input wire logic              reset_i,
  input wire logic              remote_i,
  input wire logic              dcd_i,
  input wire logic              bus_ready_o,
  input wire logic [4:0]        bus_addr_o,
  input wire logic              bus_addr_ok_o,
  input wire logic              srq_o,
  input wire logic [7:0]        stb_o,
  input wire logic              rts_o,
  input wire logic              dtr_o,
  input wire logic              link_ok_o,
  input wire logic              serial_mode_o,
  input wire logic              power_on_o,
  input wire logic [11:0]       gain_o,
  input wire logic [NFAULT-1:0] fault_latched_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Remote selector is seen by the design one enabled cycle late
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_addr_range:
    assert property (bus_addr_ok_o == (!serial_mode_o
      && bus_addr_o inside {[5'h01:5'h1E]}))
    else $error("bus address acceptance wrong");
  a_ready_gate:
    assert property (bus_ready_o |-> $past(remote_i) && !serial_mode_o)
    else $error("bus ready outside parallel remote");
  a_srq_set:
    assert property ((!serial_mode_o && fault_latched_o != '0)[*2]
      |-> srq_o)
    else $error("service request missing");
  a_srq_clear:
    assert property ((fault_latched_o == '0)[*2] |-> !srq_o)
    else $error("service request without fault");
  a_stb_lowest:
    assert property (fault_latched_o[0] [*2] |-> stb_o == 8'h43)
    else $error("status byte not interlock code");
  a_stb_range:
    assert property (stb_o != 8'h00 |-> stb_o inside {[8'h43:8'h4D]})
    else $error("status byte code out of range");
  a_dtr_mode:
    assert property (dtr_o == serial_mode_o)
    else $error("terminal ready wrong");
  a_link_dcd:
    assert property (link_ok_o == (dcd_i && serial_mode_o && $past(remote_i)))
    else $error("link valid wrong");
  a_rts_gate:
    assert property (rts_o |-> serial_mode_o && $past(remote_i))
    else $error("request to send outside serial remote");
  a_remote_entry:
    assert property ($rose(remote_i)
      |-> ##[1:3] (!power_on_o && gain_o == 12'hFFF))
    else $error("remote entry state wrong");
endmodule

bind rci_top rci_assertions #(
  .BAUD_DIV_A(BAUD_DIV_A),
  .BAUD_DIV_B(BAUD_DIV_B)
) u_chk (
  .core_clk_i, .reset_i, .remote_i, .dcd_i, .bus_ready_o, .bus_addr_o,
  .bus_addr_ok_o, .srq_o, .stb_o, .rts_o, .dtr_o, .link_ok_o,
  .serial_mode_o, .power_on_o, .gain_o, .fault_latched_o
);

// ### test/rci_host_model.sv
// Purpose: serial host on the far side of the line
// Assumes: one bit lasts DIV clocks, line idles high
// Notes:   received characters collect in rx_q
module rci_host_model #(
  parameter int DIV = 16
) (
  input  wire logic core_clk_i,
  input  wire logic txd_i,
  input  wire logic rts_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial rxd_o = 1'b1;

  // Receiver: mid-bit sampling, LSB first, one stop
  always
  begin
    @(negedge core_clk_i iff txd_i === 1'b0);
    repeat (DIV / 2) @(negedge core_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (DIV) @(negedge core_clk_i);
      sh = {txd_i, sh[7:1]};
    end
    repeat (DIV) @(negedge core_clk_i);
    if (txd_i === 1'b1)
      rx_q.push_back(sh);
  end

  // Sender: one 8N1 character, only while gated in
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    wait (rts_i === 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge core_clk_i);
      rxd_o = fr[i];
      repeat (DIV - 1) @(negedge core_clk_i);
    end
  endtask
endmodule

// ### test/testbench.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: short divisors for the two slow rates
// Notes:   straps change only through a fresh reset
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import rci_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [5:0]        straps_i = 6'h00;
  logic              remote_i = 1'b0;
  logic [NFAULT-1:0] fault_i = '0;
  logic [7:0]        bus_data_i = 8'h00;
  logic              bus_valid_i = 1'b0;
  logic              bus_eoi_i = 1'b0;
  logic              dcd_i = 1'b1;
  logic              cts_i = 1'b1;
  logic              clk_en_i = 1'b1;
  logic              local_power_btn_i = 1'b0;
  logic              local_fault_reset_i = 1'b0;
  logic              rxd_i, txd_o, rts_o, dtr_o, link_ok_o;
  logic              serial_mode_o, power_on_o, srq_o;
  logic              bus_ready_o, bus_addr_ok_o;
  logic [4:0]        bus_addr_o;
  logic [7:0]        stb_o;
  logic [11:0]       gain_o;
  logic [NFAULT-1:0] fault_latched_o;
  int                fails = 0;
  int                n_compared = 0;
  int                cyc = 0;

  // Clock, 50 ns period
  always #25 core_clk_i = ~core_clk_i;

  rci_top #(.BAUD_DIV_A(15'h0010), .BAUD_DIV_B(15'h0008)) u_dut (
    .core_clk_i, .reset_i, .clk_en_i, .straps_i, .remote_i,
    .local_power_btn_i, .local_gain_i(12'h0AB),
    .local_fault_reset_i, .fault_i, .bus_data_i, .bus_valid_i,
    .bus_eoi_i, .bus_ready_o, .bus_addr_o, .bus_addr_ok_o, .srq_o,
    .stb_o, .rxd_i, .dcd_i, .cts_i, .txd_o, .rts_o, .dtr_o,
    .link_ok_o, .serial_mode_o, .power_on_o, .gain_o, .fault_latched_o
  );

  rci_host_model #(.DIV(16)) u_host (
    .core_clk_i, .txd_i(txd_o), .rts_i(rts_o), .rxd_o(rxd_i)
  );

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic do_reset(input logic [5:0] s);
    tick(1);
    reset_i = 1'b1;
    remote_i = 1'b0;
    straps_i = s;
    tick(3);
    reset_i = 1'b0;
    tick(3);
    chk(16'(gain_o), 16'h00AB);
    remote_i = 1'b1;
    tick(3);
    chk({3'h0, power_on_o, gain_o}, 16'h0FFF);
  endtask

  task automatic bus_send(input string s, input logic eoi);
    for (int i = 0; i < s.len(); i++)
    begin
      tick(1);
      bus_data_i = s[i];
      bus_valid_i = 1'b1;
      bus_eoi_i = eoi && (i == s.len() - 1);
    end
    tick(1);
    bus_valid_i = 1'b0;
    bus_eoi_i = 1'b0;
    tick(3);
  endtask

  task automatic cmd(input string s, input logic eoi, input logic [15:0] e);
    bus_send(s, eoi);
    chk({3'h0, power_on_o, gain_o}, e);
  endtask

  task automatic test_addr;
    logic [5:0] tbl[4] = '{6'h05, 6'h1E, 6'h00, 6'h1F};
    for (int i = 0; i < 4; i++)
    begin
      do_reset(tbl[i]);
      straps_i = 6'h2A;
      tick(3);
      chk(16'(bus_addr_o), 16'(tbl[i][4:0]));
      chk(16'(bus_addr_ok_o), 16'(i < 2));
      bus_send("P1\n", 1'b0);
      chk(16'(power_on_o), 16'(i < 2));
    end
  endtask

  task automatic test_cmds;
    cmd("P1\n", 1'b0, 16'h1FFF);
    cmd("G0123\n", 1'b0, 16'h107B);
    cmd("G4095", 1'b1, 16'h1FFF);
    cmd("G0000\n", 1'b1, 16'h1000);
    cmd("G5000\n", 1'b0, 16'h1000);
    cmd("g0001\np1\n", 1'b0, 16'h1000);
    cmd("P0\nG0002\n", 1'b0, 16'h0002);
    cmd("G12\nG00034\n", 1'b0, 16'h0002);
  endtask

  task automatic test_faults;
    for (int i = 0; i < NFAULT; i++)
    begin
      tick(1);
      fault_i = NFAULT'(1) << i;
      tick(1);
      fault_i = '0;
      tick(3);
      chk({7'h00, srq_o, stb_o}, {8'h01, 8'h43 + 8'(i)});
      bus_send("R\n", 1'b0);
      chk({7'h00, srq_o, stb_o}, 16'h0000);
    end
    fault_i = 11'h018;
    tick(3);
    chk({7'h00, srq_o, stb_o}, 16'h0146);
    fault_i = 11'h010;
    bus_send("R\n", 1'b0);
    chk({5'h00, fault_latched_o}, 16'h0010);
  endtask

  task automatic chk_rx(input string s);
    for (int k = 0; k < 4000 && u_host.rx_q.size() < s.len(); k++)
      tick(1);
    chk(16'(u_host.rx_q.size()), 16'(s.len()));
    for (int i = 0; i < s.len() && i < u_host.rx_q.size(); i++)
      chk(16'(u_host.rx_q[i]), 16'(s[i]));
    u_host.rx_q.delete();
  endtask

  task automatic host_cmd(input string s);
    for (int i = 0; i < s.len(); i++)
      u_host.send(s[i]);
    tick(3);
  endtask

  task automatic test_serial;
    fault_i = '0;
    chk(16'({dtr_o, rts_o, serial_mode_o, bus_ready_o}), 16'h000E);
    dcd_i = 1'b0;
    tick(1);
    chk(16'(link_ok_o), 16'h0000);
    dcd_i = 1'b1;
    cts_i = 1'b0;
    fault_i = 11'h007;
    tick(300);
    chk({15'h0000, txd_o}, 16'h0001);
    cts_i = 1'b1;
    chk_rx("E3\nE4\nE5\n");
    fault_i = 11'h080;
    for (int k = 0; k < 100 && txd_o !== 1'b0; k++)
      tick(1);
    cts_i = 1'b0;
    tick(400);
    chk_rx("E");
    cts_i = 1'b1;
    chk_rx("10\n");
    host_cmd("P1\nG0007\n");
    chk({3'h0, power_on_o, gain_o}, 16'h1007);
    dcd_i = 1'b0;
    host_cmd("P0\n");
    chk(16'(power_on_o), 16'h0001);
    dcd_i = 1'b1;
    host_cmd("X1\n");
    tick(400);
    chk(16'(u_host.rx_q.size()), 16'h0000);
  endtask

  // Local controls, bus refusal in local mode, clock-enable freeze
  task automatic test_local;
    fault_i = '0;
    remote_i = 1'b0;
    local_fault_reset_i = 1'b1;
    tick(2);
    local_fault_reset_i = 1'b0;
    chk({5'h00, fault_latched_o}, 16'h0000);
    local_power_btn_i = 1'b1;
    tick(2);
    local_power_btn_i = 1'b0;
    chk({3'h0, power_on_o, gain_o}, 16'h10AB);
    bus_send("P0\n", 1'b0);
    chk(16'(power_on_o), 16'h0001);
    clk_en_i = 1'b0;
    fault_i = 11'h001;
    tick(3);
    chk({7'h00, srq_o, stb_o}, 16'h0000);
    fault_i = '0;
    clk_en_i = 1'b1;
    remote_i = 1'b1;
    tick(3);
    chk({3'h0, power_on_o, gain_o}, 16'h0FFF);
  endtask

  // Strap two alone: start bit lasts the shrunk 2400 divisor (8)
  task automatic test_rate;
    int n;
    n = 0;
    fault_i = 11'h180;
    for (int k = 0; k < 100 && txd_o !== 1'b0; k++)
      tick(1);
    while (txd_o === 1'b0 && n < 40)
    begin
      n++;
      tick(1);
    end
    chk(16'(n), 16'h0008);
  endtask

  // Main sequence
  initial
  begin
    test_addr();
    do_reset(6'h05);
    test_cmds();
    test_faults();
    test_local();
    do_reset(6'h21);
    test_serial();
    do_reset(6'h22);
    test_rate();
    stop_test();
  end
endmodule
